/* common/trig_latch_pkg.sv */
// shared constants and carriers of the trigger latch block
package trig_latch_pkg;
  // ==========================================================
  // sizes
  localparam int CHANNELS = 64;
  localparam int CHAN_W   = 6;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SEL_W    = 4;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_MANUAL_LO = 8'h00;
  localparam logic [7:0] OFS_MANUAL_HI = 8'h04;
  localparam logic [7:0] OFS_CHAIN_LO  = 8'h08;
  localparam logic [7:0] OFS_CHAIN_HI  = 8'h0C;
  localparam logic [7:0] OFS_CLEAR_LO  = 8'h10;
  localparam logic [7:0] OFS_CLEAR_HI  = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;
  // ==========================================================
  // interrupt status fields
  localparam int IRQ_W          = 3;
  localparam int IRQ_MANUAL_MISS = 0;
  localparam int IRQ_CHAIN_MISS  = 1;
  localparam int IRQ_CHAIN_SET   = 2;
  // ==========================================================
  // reset values
  localparam logic [63:0] RST_BANK = 64'h0000_0000_0000_0000;
  localparam logic [2:0]  RST_IRQ  = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic       valid;
    logic [5:0] chan;
  } chan_event_type;
endpackage : trig_latch_pkg

/* core/miss_queue.sv */
// queue of lost-trigger channels, one pulse per cycle
`timescale 1ns/1ps
`default_nettype none
module miss_queue #(
  parameter int CHANNELS = 64
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic [CHANNELS-1:0]           set_i,
  output var  trig_latch_pkg::chan_event_type miss_o
);
  // ==========================================================
  // pending losses
  logic [CHANNELS-1:0] pend;
  logic [CHANNELS-1:0] next_pend;
  logic [CHANNELS-1:0] pick;
  logic [5:0]          pick_chan;
  logic                pick_any;

  // lowest index first; repeats of a waiting channel coalesce
  always_comb begin
    pick      = '0;
    pick_chan = '0;
    pick_any  = 1'b0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick      = '0;
        pick[i]   = 1'b1;
        pick_chan = 6'(i);
        pick_any  = 1'b1;
      end
    end
    // new loss wins over the drain of the same bit
    next_pend = (pend & ~pick) | set_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= '0;
    end else if (ce_i) begin
      pend <= next_pend;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miss_o <= '0;
    end else if (ce_i) begin
      miss_o.valid <= pick_any;
      miss_o.chan  <= pick_chan;
    end
  end
endmodule : miss_queue
`default_nettype wire

/* core/trig_latch.sv */
// manual and chain trigger latches with wishbone register port
// Behaviour
// - writing one sets manual bit, zero ignored
// - manual bit pending regardless of enables
// - clear bank writes never touch manual
// - manual bit clears only on submission
// - set beats hardware clear, both banks
// - set on set bit plus clear flags loss
// - set on clear bit stays pending
// - rewriting a set manual bit flags loss
// - low word channels 0-31, high 32-63
// - any set bit is offered as pending
// - completion code selects chain bit
// - chain sets ungated, controller or early path
// - chain bit clears when serviced
// - chain code on set bit flags loss
// - chain read-only, manual rw, reset zero
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module trig_latch #(
  parameter int CHANNELS = 64
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           ce_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [7:0]                     wb_adr_i,
  input  wire logic [31:0]                    wb_dat_i,
  input  wire logic [3:0]                     wb_sel_i,
  output logic [31:0]                         wb_dat_o,
  output logic                                wb_ack_o,
  input  wire trig_latch_pkg::chan_event_type tc_code_i,
  input  wire trig_latch_pkg::chan_event_type early_code_i,
  input  wire trig_latch_pkg::chan_event_type manual_done_i,
  input  wire trig_latch_pkg::chan_event_type chain_done_i,
  output logic [CHANNELS-1:0]                 pending_o,
  output trig_latch_pkg::chan_event_type      miss_o,
  output logic                                irq_o
);
  // ==========================================================
  // helpers
  function automatic logic [63:0] onehot(
    input trig_latch_pkg::chan_event_type ev
  );
    logic [63:0] v;
    v = '0;
    if (ev.valid) begin
      v[ev.chan] = 1'b1;
    end
    return v;
  endfunction : onehot

  function automatic logic [31:0] lanes(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : lanes

  // ==========================================================
  // bus decode
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] wmask;
  logic        wr_man_lo;
  logic        wr_man_hi;
  logic        wr_mask;
  logic        rd_stat;

  // request acts on the edge where the master sees ack high
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & wb_we_i & wb_ack_o;
  assign bus_rd  = bus_req & ~wb_we_i & wb_ack_o;
  assign wmask   = wb_dat_i & lanes(wb_sel_i);

  always_comb begin
    wr_man_lo = 1'b0;
    wr_man_hi = 1'b0;
    wr_mask   = 1'b0;
    rd_stat   = 1'b0;
    if (wb_adr_i == trig_latch_pkg::OFS_MANUAL_LO) begin
      wr_man_lo = bus_wr;
    end else if (wb_adr_i == trig_latch_pkg::OFS_MANUAL_HI) begin
      wr_man_hi = bus_wr;
    end else if (wb_adr_i == trig_latch_pkg::OFS_IRQ_MASK) begin
      wr_mask = bus_wr;
    end else if (wb_adr_i == trig_latch_pkg::OFS_IRQ_STAT) begin
      rd_stat = bus_rd;
    end
  end

  // ==========================================================
  // manual bank
  logic [63:0] manual;
  logic [63:0] man_set;
  logic [63:0] man_clr;
  logic [63:0] man_miss;
  logic [63:0] next_manual;

  always_comb begin
    // low word channels 0-31, high 32-63
    // only ones in the written data set bits
    man_set = {wr_man_hi ? wmask : 32'h0000_0000,
               wr_man_lo ? wmask : 32'h0000_0000};
    // clear bank writes are not a clear source here
    man_clr = onehot(manual_done_i);
    // rewrite of a set bit, with or without clear
    // loss on rewrite of set bit
    man_miss = man_set & manual;
    // clear bit with set and clear stays set
    next_manual = (manual & ~man_clr) | man_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      manual <= trig_latch_pkg::RST_BANK;
    end else if (ce_i) begin
      manual <= next_manual;
    end
  end

  // ==========================================================
  // chain bank
  logic [63:0] chain;
  logic [63:0] ch_set;
  logic [63:0] ch_clr;
  logic [63:0] ch_dup;
  logic [63:0] ch_miss;
  logic [63:0] next_chain;

  always_comb begin
    // both sources set, no enable gating
    ch_set = onehot(tc_code_i) | onehot(early_code_i);
    // two codes for one channel in a cycle lose one trigger
    ch_dup = onehot(tc_code_i) & onehot(early_code_i);
    ch_clr = onehot(chain_done_i);
    // code on an already set bit is a loss
    ch_miss = (ch_set & chain) | ch_dup;
    next_chain = (chain & ~ch_clr) | ch_set;
  end

  // chain bank read-only, resets to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain <= trig_latch_pkg::RST_BANK;
    end else if (ce_i) begin
      chain <= next_chain;
    end
  end

  // ==========================================================
  // pending to prioritizer
  // no enable term in the pending path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_o <= '0;
    end else if (ce_i) begin
      pending_o <= next_manual | next_chain;
    end
  end

  // ==========================================================
  // lost-trigger reporting
  // losses drained as tagged pulses
  miss_queue #(
    .CHANNELS (CHANNELS)
  ) u_miss (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .set_i  (man_miss | ch_miss),
    .miss_o (miss_o)
  );

  // ==========================================================
  // interrupt status and mask
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic [2:0] next_stat;
  logic [2:0] next_mask;

  always_comb begin
    irq_set = '0;
    irq_set[trig_latch_pkg::IRQ_MANUAL_MISS] = |man_miss;
    irq_set[trig_latch_pkg::IRQ_CHAIN_MISS]  = |ch_miss;
    irq_set[trig_latch_pkg::IRQ_CHAIN_SET]   = |ch_set;
    // clear only what the read returned, so a later event is never lost
    next_stat = (rd_stat ? (irq_stat & ~wb_dat_o[2:0]) : irq_stat) | irq_set;
    next_mask = wr_mask ? wmask[2:0] : irq_mask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= trig_latch_pkg::RST_IRQ;
      irq_mask <= trig_latch_pkg::RST_IRQ;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      irq_stat <= next_stat;
      irq_mask <= next_mask;
      irq_o    <= |(next_stat & next_mask);
    end
  end

  // ==========================================================
  // bus answer
  logic [31:0] rdata;

  // unmapped and write-only offsets read zero
  always_comb begin
    rdata = trig_latch_pkg::RST_WORD;
    if (wb_adr_i == trig_latch_pkg::OFS_MANUAL_LO) begin
      rdata = manual[31:0];
    end else if (wb_adr_i == trig_latch_pkg::OFS_MANUAL_HI) begin
      rdata = manual[63:32];
    end else if (wb_adr_i == trig_latch_pkg::OFS_CHAIN_LO) begin
      rdata = chain[31:0];
    end else if (wb_adr_i == trig_latch_pkg::OFS_CHAIN_HI) begin
      rdata = chain[63:32];
    end else if (wb_adr_i == trig_latch_pkg::OFS_IRQ_STAT) begin
      rdata = {29'h0000_0000, irq_stat};
    end else if (wb_adr_i == trig_latch_pkg::OFS_IRQ_MASK) begin
      rdata = {29'h0000_0000, irq_mask};
    end
  end

  // single-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= trig_latch_pkg::RST_WORD;
    end else if (ce_i) begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= (bus_req & ~wb_ack_o & ~wb_we_i) ? rdata
                                                   : wb_dat_o;
    end
  end

  // ==========================================================
  // checks
  logic [2:0] read_bits;

  assign read_bits = wb_dat_o[2:0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req_seen;
    ce_i && bus_req && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_single: assert property (
    s_req_seen ##1 ce_i |-> s_ack_pulse)
    else $error("ack not a single pulse");

  a_manual_set: assert property (
    ce_i && wr_man_lo |=> (manual[31:0] & $past(wmask)) == $past(wmask))
    else $error("manual write did not set bits");

  a_manual_keep: assert property (
    ce_i && !manual_done_i.valid |=> (manual & $past(manual))
      == $past(manual))
    else $error("manual bit cleared without submission");

  a_manual_done: assert property (
    ce_i && manual_done_i.valid && !man_set[manual_done_i.chan]
      |=> !manual[$past(manual_done_i.chan)])
    else $error("submitted manual bit not cleared");

  a_set_wins: assert property (
    ce_i && manual_done_i.valid && man_set[manual_done_i.chan]
      |=> manual[$past(manual_done_i.chan)])
    else $error("clear beat set on manual bit");

  a_loss_report: assert property (
    ce_i && (|man_miss) |-> ##[1:70] miss_o.valid)
    else $error("lost manual trigger not reported");

  a_pending_view: assert property (
    pending_o == (manual | chain))
    else $error("pending differs from banks");

  a_chain_set: assert property (
    ce_i && tc_code_i.valid |=> chain[$past(tc_code_i.chan)])
    else $error("chain code did not set bit");

  a_chain_done: assert property (
    ce_i && chain_done_i.valid && !ch_set[chain_done_i.chan]
      |=> !chain[$past(chain_done_i.chan)])
    else $error("serviced chain bit not cleared");

  a_chain_loss: assert property (
    ce_i && (|ch_miss) |=> irq_stat[trig_latch_pkg::IRQ_CHAIN_MISS])
    else $error("chain loss not flagged");

  a_irq_level: assert property (
    irq_o == |(irq_stat & irq_mask))
    else $error("irq does not follow masked status");

  a_manual_set_hi: assert property (
    ce_i && wr_man_hi |=> (manual[63:32] & $past(wmask)) == $past(wmask))
    else $error("manual high write did not set bits");

  a_manual_loss: assert property (
    ce_i && (|man_miss) |=> irq_stat[trig_latch_pkg::IRQ_MANUAL_MISS])
    else $error("manual loss not flagged");

  a_early_set: assert property (
    ce_i && early_code_i.valid |=> chain[$past(early_code_i.chan)])
    else $error("early code did not set bit");

  a_chain_readonly: assert property (
    ce_i && !(|ch_set) && !chain_done_i.valid |=> chain == $past(chain))
    else $error("chain bank changed without a source");

  a_status_clear: assert property (
    ce_i && rd_stat && !(|irq_set)
      |=> irq_stat == ($past(irq_stat) & ~$past(read_bits)))
    else $error("status read did not clear returned bits");

  a_enable_freeze: assert property (
    !ce_i |=> manual == $past(manual) && chain == $past(chain)
      && irq_stat == $past(irq_stat) && wb_ack_o == $past(wb_ack_o))
    else $error("state moved while clock enable low");
endmodule : trig_latch
`default_nettype wire

/* bench/tc_model.sv */
// far-side transfer controller model issuing completion codes
`timescale 1ns/1ps
`default_nettype none
module tc_model (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire trig_latch_pkg::chan_event_type req_i,
  input  wire logic                           early_i,
  input  wire logic                           slow_i,
  output var  trig_latch_pkg::chan_event_type tc_o,
  output var  trig_latch_pkg::chan_event_type early_o
);
  trig_latch_pkg::chan_event_type hold;
  logic [1:0]                     cnt;
  logic                           use_early;
  // ==========================================================
  // code issue
  // one code per request
  always_ff @(posedge clk_i) begin
    tc_o.valid    <= 1'b0;
    early_o.valid <= 1'b0;
    // idle channel field keeps moving, so stale values never look valid
    tc_o.chan     <= ~tc_o.chan;
    early_o.chan  <= ~early_o.chan;
    if (rst_i) begin
      cnt     <= 2'h0;
      tc_o    <= '0;
      early_o <= '0;
    end else if (req_i.valid) begin
      hold      <= req_i;
      use_early <= early_i;
      cnt       <= slow_i ? 2'h3 : 2'h1;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      if (cnt == 2'h1) begin
        if (use_early) begin
          early_o <= hold;
        end else begin
          tc_o <= hold;
        end
      end
    end
  end
endmodule : tc_model
`default_nettype wire

/* bench/dma_manual_chain_event_latch_bench.sv */
// self-checking bench of the manual and chain trigger latches
`timescale 1ns/1ps
`default_nettype none
module dma_manual_chain_event_latch_bench;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] re;
  } row_type;
  logic                           clk_i, rst_i, cyc, stb, we, ack, irq;
  logic                           early, slow, ce;
  logic [7:0]                     adr;
  logic [31:0]                    wdat, rdat, q;
  logic [3:0]                     sel;
  logic [63:0]                    pend;
  trig_latch_pkg::chan_event_type req, tc, ec, mdone, cdone, miss;
  int                             n_mismatch, total_checks, n;
  row_type rows [8] = '{
    '{8'h00, 32'h0000_0011, 8'h00, 32'h0000_0011},
    '{8'h00, 32'h0000_0000, 8'h00, 32'h0000_0011},
    '{8'h04, 32'h8000_0001, 8'h04, 32'h8000_0001},
    '{8'h10, 32'hFFFF_FFFF, 8'h00, 32'h0000_0011},
    '{8'h14, 32'hFFFF_FFFF, 8'h04, 32'h8000_0001},
    '{8'h08, 32'hFFFF_FFFF, 8'h08, 32'h0000_0000},
    '{8'h40, 32'hFFFF_FFFF, 8'h40, 32'h0000_0000},
    '{8'h1C, 32'h0000_0007, 8'h1C, 32'h0000_0007}};

  trig_latch trig_latch_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tc_code_i(tc), .early_code_i(ec), .manual_done_i(mdone),
    .chain_done_i(cdone), .pending_o(pend), .miss_o(miss), .irq_o(irq));
  tc_model tc_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .early_i(early), .slow_i(slow), .tc_o(tc), .early_o(ec));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // no fixed latency assumed: wait for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wb

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, {32'h0000_0000, e}, {32'h0000_0000, q});
  endtask : rd_chk

  task automatic wait_miss(input logic [5:0] c);
    int k;
    k = 0;
    while (miss.valid !== 1'b1 && k < 10) begin
      @(posedge clk_i);
      k++;
    end
    chk("miss_valid", 64'h1, {63'h0, miss.valid});
    chk("miss_chan", {58'h0, c}, {58'h0, miss.chan});
  endtask : wait_miss

  // done lines up with the code when the model answers promptly
  task automatic code(input logic [5:0] c, input logic e, input logic s,
                      input logic d);
    @(posedge clk_i);
    req   <= {1'b1, c};
    early <= e;
    slow  <= s;
    @(posedge clk_i);
    req.valid <= 1'b0;
    @(posedge clk_i);
    cdone <= {d, c};
    @(posedge clk_i);
    cdone.valid <= 1'b0;
  endtask : code

  // write and submission of one channel land on the same edge
  task automatic coincide(input logic [5:0] c);
    fork
      wb(1'b1, 8'h00, 32'h0000_0001 << c);
      begin
        repeat (2) @(posedge clk_i);
        mdone <= {1'b1, c};
        @(posedge clk_i);
        mdone.valid <= 1'b0;
      end
    join
  endtask : coincide
  // ==========================================================
  // main sequence
  initial begin
    {cyc, stb, we, early, slow} = 5'h00;
    ce = 1'b1;
    {adr, wdat, sel} = {8'h00, 32'h0000_0000, 4'hF};
    {req, mdone, cdone} = '0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk("reset_value", 8'(4 * i), 32'h0);
    chk("pending_reset", 64'h0, pend);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].wa, rows[i].wd);
      rd_chk("row_read", rows[i].ra, rows[i].re);
    end
    chk("pending", 64'h8000_0001_0000_0011, pend);
    wb(1'b1, 8'h04, 32'hFFFF_FFFF, 4'h2);
    rd_chk("manual_hi_lane", 8'h04, 32'h8000_FF01);
    wb(1'b1, 8'h00, 32'h0000_0001);
    wait_miss(6'd0);
    @(posedge clk_i);
    mdone <= {1'b1, 6'd4};
    @(posedge clk_i);
    mdone.valid <= 1'b0;
    rd_chk("manual_lo", 8'h00, 32'h0000_0001);
    coincide(6'd4);
    coincide(6'd0);
    wait_miss(6'd0);
    rd_chk("manual_lo_both", 8'h00, 32'h0000_0011);
    code(6'd37, 1'b0, 1'b0, 1'b0);
    rd_chk("chain_hi", 8'h0C, 32'h0000_0020);
    chk("pending_37", 64'h1, {63'h0, pend[37]});
    code(6'd37, 1'b0, 1'b0, 1'b1);
    wait_miss(6'd37);
    rd_chk("chain_hi_kept", 8'h0C, 32'h0000_0020);
    code(6'd3, 1'b0, 1'b0, 1'b1);
    rd_chk("chain_lo", 8'h08, 32'h0000_0008);
    @(posedge clk_i);
    cdone <= {1'b1, 6'd37};
    @(posedge clk_i);
    cdone.valid <= 1'b0;
    rd_chk("chain_hi_clr", 8'h0C, 32'h0000_0000);
    code(6'd2, 1'b1, 1'b1, 1'b0);
    n = 0;
    while (pend[2] !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    rd_chk("chain_lo_early", 8'h08, 32'h0000_000C);
    chk("irq_on", 64'h1, {63'h0, irq});
    rd_chk("irq_status", 8'h18, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    chk("irq_off", 64'h0, {63'h0, irq});
    wb(1'b1, 8'h1C, 32'h0000_0000);
    code(6'd9, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk_i);
    chk("irq_masked", 64'h0, {63'h0, irq});
    rd_chk("irq_status_m", 8'h18, 32'h0000_0004);
    // service request while frozen must be ignored
    @(posedge clk_i);
    ce    <= 1'b0;
    cdone <= {1'b1, 6'd2};
    repeat (2) @(posedge clk_i);
    ce          <= 1'b1;
    cdone.valid <= 1'b0;
    rd_chk("chain_lo_frozen", 8'h08, 32'h0000_020C);
    // mid-run reset returns every bank to zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk("reset_again", 8'(4 * i), 32'h0);
    chk("pending_again", 64'h0, pend);
    chk("irq_again", 64'h0, {63'h0, irq});
    report_and_stop();
  end

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : dma_manual_chain_event_latch_bench
`default_nettype wire
